// ### shared/pcc_pkg.sv
package pcc_pkg;
  // Byte offsets of the two header dwords held here
  localparam logic [7:0]  PCC_OFS_CMD_STAT  = 8'h04;
  localparam logic [7:0]  PCC_OFS_REVISION  = 8'h08;

  // Command field bit positions
  localparam int          PCC_CMD_IO_EN     = 0;
  localparam int          PCC_CMD_MEM_EN    = 1;
  localparam int          PCC_CMD_PAR_RESP  = 6;
  localparam int          PCC_CMD_ERR_REP   = 8;
  localparam int          PCC_CMD_INT_DIS   = 10;

  // Writable command bits and reset value
  localparam logic [15:0] PCC_CMD_WR_MASK   = 16'h0543;
  localparam logic [15:0] PCC_CMD_RESET     = 16'h0000;

  // Status bit positions within the dword
  localparam int          PCC_STAT_INT_PEND = 19;
  localparam int          PCC_STAT_CAP_LIST = 20;
  localparam int          PCC_STAT_SIG_CA   = 27;
  localparam int          PCC_STAT_SIG_SERR = 30;
  localparam int          PCC_STAT_DET_PAR  = 31;

  // Bits of the command/status dword that never read as one
  localparam logic [31:0] PCC_RO_ZERO_MASK  = 32'h37e7fabc;

  // Capability list bit value after reset
  localparam logic        PCC_CAP_LIST_VAL  = 1'b1;

  // Sticky flag slots in the flag bank
  localparam int          PCC_FLG_CA        = 0;
  localparam int          PCC_FLG_SERR      = 1;
  localparam int          PCC_FLG_PAR       = 2;
  localparam int          PCC_NFLAGS        = 3;
  localparam logic [2:0]  PCC_FLAGS_RESET   = 3'h0;

  // Revision field width
  localparam int          PCC_REV_W         = 8;
endpackage

// ### shared/pcc_flag_if.sv
interface pcc_flag_if #(
  parameter int N = 3
);
  logic [N-1:0] set;
  logic [N-1:0] clr;
  logic [N-1:0] flags;

  modport bank (input set, input clr, output flags);
  modport user (output set, output clr, input flags);
endinterface

// ### src/pcc_flag_bank.sv
module pcc_flag_bank #(
  parameter int N = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Flag set/clear/value carrier
  pcc_flag_if.bank fl
);
  import pcc_pkg::*;

  logic [N-1:0] flags;
  logic [N-1:0] next_flags;

  // One sticky bit per slot; a set in the clearing cycle survives
  for (genvar i = 0; i < N; i++) begin : g_flag
    always_comb begin
      next_flags[i] = fl.set[i] | (flags[i] & ~fl.clr[i]); // R15
    end

    AST_FLAG_SET_WINS: assert property (@(posedge clk) disable iff (!reset_n) // R15
      fl.set[i] |=> flags[i])
      else $error("flag lost its set event");

    AST_FLAG_W1C: assert property (@(posedge clk) disable iff (!reset_n) // R15
      fl.clr[i] && !fl.set[i] |=> !flags[i])
      else $error("flag not cleared by write of one");

    AST_FLAG_HOLD: assert property (@(posedge clk) disable iff (!reset_n) // R15
      !fl.set[i] && !fl.clr[i] |=> flags[i] == $past(flags[i]))
      else $error("flag changed without cause");
  end

  // Register only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flags <= N'(PCC_FLAGS_RESET);
    end else begin
      flags <= next_flags;
    end
  end

  assign fl.flags = flags;
endmodule

// ### src/pcc_cfg_cmd_stat.sv
// Notes on behaviour
// R1: I/O requests are accepted only while command bit 0 is set; resets clear.
// R2: Memory requests are accepted only while command bit 1 is set; resets clear.
// R3: Command bits 3,4,5,7,9 and status bits 21,23,26:25 read zero.
// R4: Command bit 6 enables parity error action; clear only sets detected-parity flag.
// R5: Command bit 8 enables sending fatal and non-fatal error messages.
// R6: Command bit 10 set suppresses legacy interrupt messages.
// R7: Command bits 15:11 reserved, read zero.
// R8: Status bits 18:16 reserved, read zero.
// R9: Status bit 19 shows an internally pending legacy interrupt.
// R10: Status bit 20 reads one, capability pointer lives at 0x34.
// R11: Command bit 2 and status bits 24,28,29 read zero.
// R12: Status bit 27 set on completer-abort completion.
// R13: Status bit 30 set when an error message is sent with bit 8 set.
// R14: Status bit 31 set on a received poisoned TLP.
// R15: Write-one-to-clear flags clear on a written one; zero leaves them.
// R16: Revision byte at 0x08 read-only; EEPROM autoload may replace it.
// R17: Writes to read-only bits ignored; byte enables limit written bytes.
module pcc_cfg_cmd_stat #(
  parameter logic [7:0] REV_DEFAULT = 8'h3c // Arbitrary default revision
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  // Configuration access from the root complex
  input  wire logic                      cfg_req,
  input  wire logic                      cfg_we,
  input  wire logic [7:0]                cfg_addr,
  input  wire logic [3:0]                cfg_be,
  input  wire logic [31:0]               cfg_wdata,
  output logic                           cfg_ack,
  output logic [31:0]                    cfg_rdata,
  // Space decode gating
  input  wire logic                      io_req,
  output logic                           io_accept,
  input  wire logic                      mem_req,
  output logic                           mem_accept,
  // Error events and reporting
  input  wire logic                      completer_abort,
  input  wire logic                      poisoned_tlp,
  input  wire logic                      parity_err,
  output logic                           parity_action,
  input  wire logic                      err_fatal_req,
  input  wire logic                      err_nonfatal_req,
  output logic                           err_msg_send,
  output logic                           err_msg_fatal,
  // Legacy interrupt
  input  wire logic                      intx_pending,
  output logic                           intx_msg_req,
  // Revision autoload
  input  wire logic                      rev_load_valid,
  input  wire logic [pcc_pkg::PCC_REV_W-1:0] rev_load_data,
  // Current fields for the rest of the bridge
  output logic [15:0]                    command_control,
  output logic [pcc_pkg::PCC_REV_W-1:0]  revision_number
);
  import pcc_pkg::*;

  // Dword decode, shared by read and write paths
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr[7:2] == ofs[7:2]);
  endfunction

  logic [15:0]          next_command;
  logic [PCC_REV_W-1:0] next_revision;
  logic                 next_ack;
  logic [31:0]          next_rdata;
  logic                 wr_cmd;
  logic                 intx_pend;
  logic [15:0]          cmd_be_mask;

  pcc_flag_if #(.N(PCC_NFLAGS)) flg ();

  pcc_flag_bank #(.N(PCC_NFLAGS)) u_flags (
    .clk     (clk),
    .reset_n (reset_n),
    .fl      (flg.bank)
  );

  // Decode and error gating are combinational so a request is judged
  // against the enable in force in its own cycle
  always_comb begin
    io_accept     = io_req && command_control[PCC_CMD_IO_EN];     // R1
    mem_accept    = mem_req && command_control[PCC_CMD_MEM_EN];   // R2
    parity_action = parity_err && command_control[PCC_CMD_PAR_RESP]; // R4
    err_msg_send  = (err_fatal_req || err_nonfatal_req)
                    && command_control[PCC_CMD_ERR_REP];          // R5
    err_msg_fatal = err_fatal_req && command_control[PCC_CMD_ERR_REP];
    intx_msg_req  = intx_pend && !command_control[PCC_CMD_INT_DIS]; // R6
  end

  // Sticky status events; clears come from a byte-3 write of ones
  always_comb begin
    flg.set = '0;
    flg.clr = '0;
    flg.set[PCC_FLG_CA]   = completer_abort;                      // R12
    flg.set[PCC_FLG_SERR] = err_msg_send;                         // R13
    flg.set[PCC_FLG_PAR]  = poisoned_tlp || parity_err;           // R14 R4
    if (wr_cmd && cfg_be[3]) begin                                // R17
      flg.clr[PCC_FLG_CA]   = cfg_wdata[PCC_STAT_SIG_CA];         // R15
      flg.clr[PCC_FLG_SERR] = cfg_wdata[PCC_STAT_SIG_SERR];       // R15
      flg.clr[PCC_FLG_PAR]  = cfg_wdata[PCC_STAT_DET_PAR];        // R15
    end
  end

  // Command and revision next values; only writable command bits in enabled
  // bytes and an autoloaded revision move, everything else is kept
  always_comb begin
    wr_cmd        = cfg_req && cfg_we && hit(cfg_addr, PCC_OFS_CMD_STAT);
    cmd_be_mask   = {{8{cfg_be[1]}}, {8{cfg_be[0]}}} & PCC_CMD_WR_MASK; // R17
    next_command  = command_control;
    if (wr_cmd) begin
      next_command = (command_control & ~cmd_be_mask)
                     | (cfg_wdata[15:0] & cmd_be_mask);           // R1 R2 R4 R5 R6 R7
    end
    next_revision = revision_number;
    if (rev_load_valid) begin
      next_revision = rev_load_data;                              // R16
    end
  end

  // Read data: hardwired and reserved bits stay zero by construction
  always_comb begin
    next_ack   = cfg_req;
    next_rdata = 32'h0000_0000;
    if (cfg_req && !cfg_we) begin
      if (hit(cfg_addr, PCC_OFS_CMD_STAT)) begin
        next_rdata[15:0]              = command_control;          // R3 R7 R11
        next_rdata[PCC_STAT_INT_PEND] = intx_pend;                // R9 R8
        next_rdata[PCC_STAT_CAP_LIST] = PCC_CAP_LIST_VAL;         // R10
        next_rdata[PCC_STAT_SIG_CA]   = flg.flags[PCC_FLG_CA];
        next_rdata[PCC_STAT_SIG_SERR] = flg.flags[PCC_FLG_SERR];
        next_rdata[PCC_STAT_DET_PAR]  = flg.flags[PCC_FLG_PAR];
      end else if (hit(cfg_addr, PCC_OFS_REVISION)) begin
        next_rdata[PCC_REV_W-1:0]     = revision_number;          // R16
      end
    end
  end

  // Register all state except the sticky flags held in u_flags; revision default reloads at reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      command_control <= PCC_CMD_RESET;
      revision_number <= REV_DEFAULT;
      intx_pend       <= 1'b0;
      cfg_ack         <= 1'b0;
      cfg_rdata       <= 32'h0000_0000;
    end else begin
      command_control <= next_command;
      revision_number <= next_revision;
      intx_pend       <= intx_pending;   // R9
      cfg_ack         <= next_ack;
      cfg_rdata       <= next_rdata;
    end
  end

  // Checks on behaviour
  sequence s_cmd_read;
    cfg_req && !cfg_we && hit(cfg_addr, PCC_OFS_CMD_STAT);
  endsequence

  sequence s_cmd_write_lo;
    cfg_req && cfg_we && hit(cfg_addr, PCC_OFS_CMD_STAT) && cfg_be[0];
  endsequence

  sequence s_cmd_write_no_lo;
    cfg_req && cfg_we && hit(cfg_addr, PCC_OFS_CMD_STAT) && !cfg_be[0];
  endsequence

  AST_IO_GATE: assert property (@(posedge clk) disable iff (!reset_n) // R1
    s_cmd_write_lo ##1 (io_req && !cfg_req) |-> io_accept == $past(cfg_wdata[PCC_CMD_IO_EN]))
    else $error("I/O accept does not follow written enable");

  AST_MEM_GATE: assert property (@(posedge clk) disable iff (!reset_n) // R2
    mem_req && !command_control[PCC_CMD_MEM_EN] |-> !mem_accept)
    else $error("memory request accepted while disabled");

  AST_RO_ZERO: assert property (@(posedge clk) disable iff (!reset_n) // R3
    s_cmd_read |=> cfg_ack && ((cfg_rdata & PCC_RO_ZERO_MASK) == 32'h0000_0000))
    else $error("hardwired or reserved bit read as one");

  AST_CAP_LIST: assert property (@(posedge clk) disable iff (!reset_n) // R10
    s_cmd_read |=> cfg_rdata[PCC_STAT_CAP_LIST])
    else $error("capability list bit not set");

  AST_PAR_ONLY_FLAG: assert property (@(posedge clk) disable iff (!reset_n) // R4
    parity_err && !command_control[PCC_CMD_PAR_RESP] |-> !parity_action ##1 flg.flags[PCC_FLG_PAR])
    else $error("parity handling wrong with response disabled");

  AST_SERR_FLAG: assert property (@(posedge clk) disable iff (!reset_n) // R13
    (err_fatal_req || err_nonfatal_req) |->
      (err_msg_send == command_control[PCC_CMD_ERR_REP]) ##1
      (flg.flags[PCC_FLG_SERR] || !$past(command_control[PCC_CMD_ERR_REP])))
    else $error("error message or signalled error flag wrong");

  AST_INTX_DIS: assert property (@(posedge clk) disable iff (!reset_n) // R6
    intx_msg_req |-> !command_control[PCC_CMD_INT_DIS] && $past(intx_pending))
    else $error("interrupt message while disabled");

  AST_CA_SET: assert property (@(posedge clk) disable iff (!reset_n) // R12
    completer_abort ##1 s_cmd_read |=> cfg_rdata[PCC_STAT_SIG_CA])
    else $error("completer abort not reported");

  AST_REV_LOAD: assert property (@(posedge clk) disable iff (!reset_n) // R16
    rev_load_valid |=> revision_number == $past(rev_load_data))
    else $error("revision autoload not taken");

  AST_BE_MASK: assert property (@(posedge clk) disable iff (!reset_n) // R17
    s_cmd_write_no_lo |=> command_control[7:0] == $past(command_control[7:0]))
    else $error("disabled byte lane was written");
endmodule

// ### tb/pcc_rc_model.sv
module pcc_rc_model (
  // Clock
  input  wire logic        clk,
  // Requests towards the device
  output logic             cfg_req,
  output logic             cfg_we,
  output logic [7:0]       cfg_addr,
  output logic [3:0]       cfg_be,
  output logic [31:0]      cfg_wdata,
  // Answers from the device
  input  wire logic        cfg_ack,
  input  wire logic [31:0] cfg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // Quiet bus at time zero
  initial begin
    cfg_req = 1'b0;
    cfg_we = 1'b0;
    cfg_addr = 8'h00;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0;
  end

  // One dword access; rd is unknown if the ack is missing
  task automatic xfer(input logic we, input logic [7:0] a, input logic [3:0] be,
                      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    #1;
    cfg_req = 1'b1;
    cfg_we = we;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = wd;
    @(posedge clk);
    #1;
    cfg_req = 1'b0;
    // Released lines show garbage, not the last value
    cfg_addr = ~a;
    cfg_wdata = ~wd;
    cfg_be = ~be;
    rd = (cfg_ack === 1'b1) ? cfg_rdata : 32'hxxxxxxxx;
  endtask
endmodule

// ### tb/pcie_cfg_command_status_tb.sv
module pcie_cfg_command_status_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import pcc_pkg::*;

  localparam logic [7:0] REV = 8'h3c; // Arbitrary revision value
  typedef struct packed {
    logic        we;
    logic [7:0]  a;
    logic [3:0]  be;
    logic [31:0] wd;
    logic [31:0] ex;
  } pcc_row_t;

  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        cfg_req, cfg_we, cfg_ack;
  logic [7:0]  cfg_addr, revision_number;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata;
  logic        io_req = 0, io_accept, mem_req = 0, mem_accept;
  logic        completer_abort = 0, poisoned_tlp = 0, parity_err = 0, parity_action;
  logic        err_fatal_req = 0, err_nonfatal_req = 0, err_msg_send, err_msg_fatal;
  logic        intx_pending = 0, intx_msg_req, rev_load_valid = 0;
  logic [7:0]  rev_load_data = 8'h00;
  logic [15:0] command_control;
  int          error_cnt = 0;
  int          checks_done = 0;
  int          cyc = 0;

  // Plain register traffic: we, address, lanes, write data, read answer
  pcc_row_t rows [11] = '{
    '{1'b0, 8'h04, 4'hf, 32'h0, 32'h00100000},
    '{1'b1, 8'h04, 4'hf, 32'hffffffff, 32'h0},
    '{1'b0, 8'h04, 4'hf, 32'h0, 32'h00100543},
    '{1'b1, 8'h04, 4'h1, 32'h0, 32'h0},
    '{1'b0, 8'h04, 4'hf, 32'h0, 32'h00100500},
    '{1'b0, 8'h08, 4'hf, 32'h0, {24'h0, REV}},
    '{1'b1, 8'h08, 4'hf, 32'hffffffff, 32'h0},
    '{1'b0, 8'h08, 4'hf, 32'h0, {24'h0, REV}},
    '{1'b0, 8'h10, 4'hf, 32'h0, 32'h0},
    '{1'b1, 8'h04, 4'hf, 32'h00000003, 32'h0},
    '{1'b0, 8'h04, 4'hf, 32'h0, 32'h00100003}
  };

  pcc_cfg_cmd_stat #(.REV_DEFAULT(REV)) pcc_cfg_cmd_stat_i (.*);
  pcc_rc_model pcc_rc_model_i (.*);

  // 25 ns clock
  initial begin
    forever #12.5 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cfg(input pcc_row_t r);
    logic [31:0] rd;
    pcc_rc_model_i.xfer(r.we, r.a, r.be, r.wd, rd);
    chk("cfg_rdata", r.ex, rd);
  endtask

  // Single-cycle event pulse, raised off the edge
  task automatic pulse(ref logic s);
    @(posedge clk);
    #1;
    s = 1'b1;
    @(posedge clk);
    #1;
    s = 1'b0;
  endtask

  task automatic print_verdict();
    if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    #1;
    reset_n = 1'b1;
    foreach (rows[i]) cfg(rows[i]);
    // Decoding enabled, reporting still off
    {io_req, mem_req, parity_err, err_fatal_req, intx_pending} = 5'h1f;
    @(posedge clk);
    #1;
    chk("io_accept", 1, io_accept);
    chk("mem_accept", 1, mem_accept);
    chk("parity_action", 0, parity_action);
    chk("err_msg_send", 0, err_msg_send);
    chk("intx_msg_req", 1, intx_msg_req);
    {parity_err, err_fatal_req} = 2'b00;
    pulse(poisoned_tlp);
    // Abort held so the read lands in the cycle right after the event
    completer_abort = 1'b1;
    cfg('{1'b0, 8'h04, 4'hf, 32'h0, 32'h88180003});
    completer_abort = 1'b0;
    cfg('{1'b1, 8'h04, 4'h3, 32'h0000ff40, 32'h0});
    {parity_err, err_fatal_req} = 2'b11;
    #1;
    chk("parity_action", 1, parity_action);
    chk("err_msg_fatal", 1, err_msg_fatal);
    chk("err_msg_send", 1, err_msg_send);
    chk("intx_msg_req", 0, intx_msg_req);
    chk("io_accept", 0, io_accept);
    chk("mem_accept", 0, mem_accept);
    @(posedge clk);
    #1;
    {parity_err, err_fatal_req, err_nonfatal_req} = 3'b001;
    #1;
    chk("err_msg_send", 1, err_msg_send);
    chk("err_msg_fatal", 0, err_msg_fatal);
    @(posedge clk);
    #1;
    err_nonfatal_req = 1'b0;
    cfg('{1'b0, 8'h04, 4'hf, 32'h0, 32'hc8180540});
    cfg('{1'b1, 8'h04, 4'h8, 32'h40000000, 32'h0});
    cfg('{1'b0, 8'h04, 4'hf, 32'h0, 32'h88180540});
    cfg('{1'b1, 8'h04, 4'h7, 32'hffffffff, 32'h0});
    cfg('{1'b0, 8'h04, 4'hf, 32'h0, 32'h88180543});
    cfg('{1'b1, 8'h04, 4'h8, 32'hffffffff, 32'h0});
    cfg('{1'b0, 8'h04, 4'hf, 32'h0, 32'h00180543});
    rev_load_data = 8'h5a;
    pulse(rev_load_valid);
    cfg('{1'b0, 8'h08, 4'hf, 32'h0, 32'h0000005a});
    // Second reset in mid-run
    intx_pending = 1'b0;
    reset_n = 1'b0;
    #1;
    chk("command_control", 0, command_control);
    chk("revision_number", REV, revision_number);
    @(posedge clk);
    #1;
    reset_n = 1'b1;
    cfg(rows[0]);
    print_verdict();
  end
endmodule
